// ===== bpcs_defs.vh
`ifndef BPCS_DEFS_VH
`define BPCS_DEFS_VH

// Register byte offsets
`define BPCS_OFS_CMD_STATUS 8'h04
`define BPCS_OFS_REV_CLASS 8'h08
`define BPCS_OFS_EVENTS 8'h40

// Command field positions
`define BPCS_CMD_IO_EN 0
`define BPCS_CMD_MEM_EN 1
`define BPCS_CMD_MASTER_EN 2
`define BPCS_CMD_SPECIAL 3
`define BPCS_CMD_MWI 4
`define BPCS_CMD_PALETTE_EN 5
`define BPCS_CMD_PARITY_RESP 6
`define BPCS_CMD_STEPPING 7
`define BPCS_CMD_SERR_EN 8
`define BPCS_CMD_FAST_B2B_EN 9
`define BPCS_CMD_RW_MASK 16'h0367
`define BPCS_CMD_RESET 16'h0000

// Status field positions in the 32-bit word
`define BPCS_ST_CAP_LIST 20
`define BPCS_ST_66MHZ 21
`define BPCS_ST_FAST_B2B 23
`define BPCS_ST_DATA_PERR 24
`define BPCS_ST_DEVSEL_LO 25
`define BPCS_ST_DEVSEL_HI 26
`define BPCS_ST_SIG_TABORT 27
`define BPCS_ST_RCV_TABORT 28
`define BPCS_ST_RCV_MABORT 29
`define BPCS_ST_SIG_SERR 30
`define BPCS_ST_DET_PERR 31
`define BPCS_DEVSEL_MEDIUM 2'h1

// Identification
`define BPCS_PROG_IF 8'h00
`define BPCS_SUB_CLASS 8'h04
`define BPCS_BASE_CLASS 8'h06

// Palette addresses, low ten bits
`define BPCS_PAL_A 10'h3C6
`define BPCS_PAL_B 10'h3C8
`define BPCS_PAL_C 10'h3C9

`endif

// ===== bpcs_regs.v
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "bpcs_defs.vh"

module bpcs_regs #(
    parameter [7:0] REVISION = 8'h5A // Arbitrary value
) (
    // Clock, reset, enable
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Bridge core events, same clock
    input wire ev_target_abort_sent,
    input wire ev_target_abort_rcvd,
    input wire ev_master_abort_rcvd,
    input wire ev_serr_request,
    input wire ev_parity_detected,
    input wire fwd_mwi_active,
    // Primary decode request, same clock
    input wire [15:0] dec_io_addr,
    input wire dec_io_write,
    // Pins
    input wire primary_parity_error_n,
    output reg primary_system_error_n_out,
    output reg primary_system_error_n_oe,
    // Control outputs
    output reg io_response_en,
    output reg mem_response_en,
    output reg master_en,
    output reg parity_action_en,
    output reg fast_b2b_en,
    output reg palette_hit
);

// Command register; read-only positions are masked off on write
reg [15:0] cmd;
// Read path
reg [31:0] next_rdata;
// System-error driver
reg serr_fire;
reg next_serr_out;
reg next_serr_oe;
// Palette snoop
reg pal_addr_match;
reg next_palette_hit;

// Decoded register strobes
wire wr_cs;
wire [15:0] clear_mask;
// Parity pin after the synchroniser
wire perr_sync_n;
wire perr_seen;
wire set_data_perr;
wire set_det_perr;
// Sticky status flags
wire st_data_perr;
wire st_sig_tabort;
wire st_rcv_tabort;
wire st_rcv_mabort;
wire st_sig_serr;
wire st_det_perr;
// Assembled read words, and the low ten bits of the palette decode address
wire [9:0] low_addr;
wire [15:0] cmd_view;
wire [15:0] status_view;
wire [31:0] id_word;

assign wr_cs = reg_wr && (reg_addr == `BPCS_OFS_CMD_STATUS);
// Write-one-to-clear request per status bit; zeros leave a flag alone
assign clear_mask = wr_cs ? reg_wdata[31:16] : 16'h0000;
assign perr_seen = ~perr_sync_n;
// Data parity needs the response enable; detected parity does not
assign set_data_perr = perr_seen && cmd[`BPCS_CMD_PARITY_RESP];
assign set_det_perr = ev_parity_detected || perr_seen;
assign low_addr = dec_io_addr[9:0];

// Read-only command positions are set here, never stored: zeros, and bit 4 from fwd_mwi_active
assign cmd_view = {
    6'h00,
    cmd[`BPCS_CMD_FAST_B2B_EN],
    cmd[`BPCS_CMD_SERR_EN],
    1'b0,
    cmd[`BPCS_CMD_PARITY_RESP],
    cmd[`BPCS_CMD_PALETTE_EN],
    fwd_mwi_active,
    1'b0,
    cmd[`BPCS_CMD_MASTER_EN],
    cmd[`BPCS_CMD_MEM_EN],
    cmd[`BPCS_CMD_IO_EN]
};

// Capability, speed and timing positions are constants
assign status_view = {
    st_det_perr,
    st_sig_serr,
    st_rcv_mabort,
    st_rcv_tabort,
    st_sig_tabort,
    `BPCS_DEVSEL_MEDIUM,
    st_data_perr,
    1'b1,
    1'b0,
    1'b1,
    1'b1,
    4'h0
};
assign id_word = {`BPCS_BASE_CLASS, `BPCS_SUB_CLASS, `BPCS_PROG_IF, REVISION};

// Pin idles high, so the synchroniser resets high to avoid a false report
bpcs_sync2 #(
    .IDLE(1'b1)
) u_perr_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .async_in(primary_parity_error_n),
    .sync_out(perr_sync_n)
);

// Unmapped offsets read zero so software can probe safely
always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
        `BPCS_OFS_CMD_STATUS: begin
            next_rdata = {status_view, cmd_view};
        end
        `BPCS_OFS_REV_CLASS: begin
            next_rdata = id_word;
        end
        default: begin
            next_rdata = 32'h0000_0000;
        end
    endcase
end

// Writes to any other offset, the identification word included, are dropped
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        cmd <= `BPCS_CMD_RESET;
    end else if (clk_en) begin
        if (wr_cs) begin
            cmd <= reg_wdata[15:0] & `BPCS_CMD_RW_MASK;
        end
    end
end

// Data stand only in the cycle after the read strobe, zero otherwise
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
        if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
end

// Each flag: a hardware set wins over a write-one clear in the same cycle
bpcs_flag u_flag_data_perr (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .set_ev(set_data_perr),
    .clear_req(clear_mask[`BPCS_ST_DATA_PERR - 16]),
    .flag_q(st_data_perr)
);

bpcs_flag u_flag_sig_tabort (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .set_ev(ev_target_abort_sent),
    .clear_req(clear_mask[`BPCS_ST_SIG_TABORT - 16]),
    .flag_q(st_sig_tabort)
);

bpcs_flag u_flag_rcv_tabort (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .set_ev(ev_target_abort_rcvd),
    .clear_req(clear_mask[`BPCS_ST_RCV_TABORT - 16]),
    .flag_q(st_rcv_tabort)
);

bpcs_flag u_flag_rcv_mabort (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .set_ev(ev_master_abort_rcvd),
    .clear_req(clear_mask[`BPCS_ST_RCV_MABORT - 16]),
    .flag_q(st_rcv_mabort)
);

bpcs_flag u_flag_sig_serr (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .set_ev(serr_fire),
    .clear_req(clear_mask[`BPCS_ST_SIG_SERR - 16]),
    .flag_q(st_sig_serr)
);

bpcs_flag u_flag_det_perr (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .set_ev(set_det_perr),
    .clear_req(clear_mask[`BPCS_ST_DET_PERR - 16]),
    .flag_q(st_det_perr)
);

// Request only reaches the pin while its driver is enabled
always @* begin
    serr_fire = ev_serr_request && cmd[`BPCS_CMD_SERR_EN];
    next_serr_out = ~serr_fire;
    next_serr_oe = serr_fire;
end

// Bits 15:10 are ISA aliases and deliberately not compared
always @* begin
    pal_addr_match = 1'b0;
    if (low_addr == `BPCS_PAL_A) begin
        pal_addr_match = 1'b1;
    end
    if (low_addr == `BPCS_PAL_B) begin
        pal_addr_match = 1'b1;
    end
    if (low_addr == `BPCS_PAL_C) begin
        pal_addr_match = 1'b1;
    end
    next_palette_hit = dec_io_write && cmd[`BPCS_CMD_PALETTE_EN] && pal_addr_match;
end

// Open-drain pin: drive low only, and only while enabled
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        primary_system_error_n_out <= 1'b1;
        primary_system_error_n_oe <= 1'b0;
    end else if (clk_en) begin
        primary_system_error_n_out <= next_serr_out;
        primary_system_error_n_oe <= next_serr_oe;
    end
end

// Enables lag the command register by one cycle
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        io_response_en <= 1'b0;
    end else if (clk_en) begin
        io_response_en <= cmd[`BPCS_CMD_IO_EN];
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        mem_response_en <= 1'b0;
    end else if (clk_en) begin
        mem_response_en <= cmd[`BPCS_CMD_MEM_EN];
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        master_en <= 1'b0;
    end else if (clk_en) begin
        master_en <= cmd[`BPCS_CMD_MASTER_EN];
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        parity_action_en <= 1'b0;
    end else if (clk_en) begin
        parity_action_en <= cmd[`BPCS_CMD_PARITY_RESP];
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        fast_b2b_en <= 1'b0;
    end else if (clk_en) begin
        fast_b2b_en <= cmd[`BPCS_CMD_FAST_B2B_EN];
    end
end

// Registered so the decoder sees a clean, glitch-free claim
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        palette_hit <= 1'b0;
    end else if (clk_en) begin
        palette_hit <= next_palette_hit;
    end
end

endmodule // bpcs_regs

// Two-flop synchroniser; only the second stage may be read
module bpcs_sync2 #(
    parameter [0:0] IDLE = 1'b1
) (
    // Clock, reset, enable
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // Pin side
    input wire async_in,
    // Synchronised level
    output reg sync_out
);

reg meta;

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        meta <= IDLE;
        sync_out <= IDLE;
    end else if (clk_en) begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule // bpcs_sync2

// Sticky event flag with write-one clear; a set in the clear cycle wins
module bpcs_flag (
    // Clock, reset, enable
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // Set and clear
    input wire set_ev,
    input wire clear_req,
    // Flag
    output reg flag_q
);

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        flag_q <= 1'b0;
    end else if (clk_en) begin
        if (set_ev) begin
            flag_q <= 1'b1;
        end else if (clear_req) begin
            flag_q <= 1'b0;
        end
    end
end

endmodule // bpcs_flag

// ===== bpcs_regs_sva.sv
`timescale 1ns/1ns
module bpcs_regs_sva #(
    parameter [7:0] REVISION = 8'h00
) (
    // Watched ports
    input wire core_clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire ev_serr_request,
    input wire fwd_mwi_active,
    input wire [15:0] dec_io_addr,
    input wire dec_io_write,
    input wire primary_system_error_n_out,
    input wire primary_system_error_n_oe,
    input wire io_response_en,
    input wire palette_hit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_id_rd;
        reg_rd && reg_addr == 8'h08;
    endsequence
    sequence s_cs_rd;
        reg_rd && reg_addr == 8'h04 && !fwd_mwi_active;
    endsequence
    a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_id_fixed: assert property (s_id_rd |=> reg_rdata == {24'h06_0400, REVISION})
        else $error("identification word wrong");
    a_fixed_bits: assert property (s_cs_rd |=>
        reg_rdata[23:16] == 8'hB0 && reg_rdata[26:25] == 2'h1 && reg_rdata[15:10] == 6'h00
        && reg_rdata[7] == 1'b0 && reg_rdata[4:3] == 2'h0)
        else $error("fixed command or status bits wrong");
    a_serr_drive_low: assert property (
        primary_system_error_n_oe |-> !primary_system_error_n_out)
        else $error("error pin driven high");
    a_serr_cause: assert property (
        $rose(primary_system_error_n_oe) |-> $past(ev_serr_request))
        else $error("error pin driven without request");
    a_pal_hit_cause: assert property (palette_hit |-> $past(dec_io_write)
        && $past(dec_io_addr[9:0]) inside {10'h3C6, 10'h3C8, 10'h3C9})
        else $error("palette hit without matching write");
    a_pal_miss: assert property (
        dec_io_write && dec_io_addr[9:0] == 10'h3C7 |=> !palette_hit)
        else $error("palette hit on neighbour address");
    a_io_en_change: assert property (
        $changed(io_response_en) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("io enable changed without a write");
endmodule // bpcs_regs_sva
bind bpcs_regs bpcs_regs_sva #(.REVISION(REVISION)) u_sva (.*);

// ===== bpcs_pbus_model.sv
`timescale 1ns/1ns
module bpcs_pbus_model (
    // Primary bus side
    input wire core_clk,
    output logic primary_parity_error_n
);
    // Pin has a pull-up, so it idles high between reports
    initial primary_parity_error_n = 1'b1;
    task automatic drive_perr(input int n);
        @(posedge core_clk);
        primary_parity_error_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        primary_parity_error_n <= 1'b1;
    endtask
endmodule // bpcs_pbus_model

// ===== bridge_primary_cmd_status_regs_test.sv
`timescale 1ns/1ns
module bridge_primary_cmd_status_regs_test;
    localparam [7:0] REV = 8'h3C; // Arbitrary value
    logic core_clk, arst_n, clk_en, reg_wr, reg_rd, fwd_mwi_active, dec_io_write;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] dec_io_addr;
    logic [4:0] ev;
    wire ev_target_abort_sent, ev_target_abort_rcvd, ev_master_abort_rcvd, ev_serr_request;
    wire ev_parity_detected, primary_parity_error_n;
    logic primary_system_error_n_out, primary_system_error_n_oe, palette_hit;
    logic io_response_en, mem_response_en, master_en, parity_action_en, fast_b2b_en;
    int error_cnt = 0;
    int n_compared = 0;
    assign {ev_serr_request, ev_parity_detected, ev_master_abort_rcvd, ev_target_abort_rcvd,
        ev_target_abort_sent} = ev;
    bpcs_regs #(.REVISION(REV)) DUT (.*);
    bpcs_pbus_model pm (.*);
    task close_out;
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input [31:0] s, input [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, e, s);
        end
    endtask
    // Events ride along with the write so set and clear can meet in one cycle
    task wr(input [7:0] a, input [31:0] d, input [4:0] m);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr, ev} <= {a, d, 1'b1, m};
        @(posedge core_clk);
        {reg_wr, ev} <= 6'h00;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge core_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask
    task pal(input [15:0] a, input logic h);
        @(posedge core_clk);
        {dec_io_addr, dec_io_write} <= {a, 1'b1};
        @(posedge core_clk);
        dec_io_write <= 1'b0;
        #1 chk("palette_hit", {31'h0, palette_hit}, {31'h0, h});
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #5_000_000;
        error_cnt++;
        close_out;
    end
    initial begin
        {arst_n, clk_en, reg_wr, reg_rd, fwd_mwi_active, dec_io_write, ev} = 11'h200;
        {reg_addr, reg_wdata, dec_io_addr} = 56'h0;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(8'h04, 32'h02B0_0000);
        wr(8'h08, 32'hFFFF_FFFF, 5'h00);
        rd(8'h08, {24'h06_0400, REV});
        rd(8'h10, 32'h0000_0000);
        wr(8'h04, 32'h0000_FFFF, 5'h00);
        rd(8'h04, 32'h02B0_0367);
        chk("enables", {io_response_en, mem_response_en, master_en, parity_action_en,
            fast_b2b_en}, 32'h1F);
        fwd_mwi_active <= 1'b1;
        rd(8'h04, 32'h02B0_0377);
        fwd_mwi_active <= 1'b0;
        pal(16'hFFC6, 1'b1);
        pal(16'h03C8, 1'b1);
        pal(16'h7FC9, 1'b1);
        pal(16'h03C7, 1'b0);
        wr(8'h10, 32'h0000_0000, 5'h1F);
        #1 chk("serr_oe", primary_system_error_n_oe, 32'h1);
        chk("serr_out", primary_system_error_n_out, 32'h0);
        rd(8'h04, 32'hFAB0_0367);
        wr(8'h04, 32'hF800_0367, 5'h01);
        rd(8'h04, 32'h0AB0_0367);
        wr(8'h04, 32'h0800_0367, 5'h00);
        rd(8'h04, 32'h02B0_0367);
        pm.drive_perr(2);
        repeat (3) @(posedge core_clk);
        rd(8'h04, 32'h83B0_0367);
        wr(8'h04, 32'hFFFF_0000, 5'h00);
        // System-error request with the driver disabled stays off the pin
        wr(8'h10, 32'h0000_0000, 5'h10);
        #1 chk("serr_oe", primary_system_error_n_oe, 32'h0);
        chk("serr_out", primary_system_error_n_out, 32'h1);
        chk("enables", {io_response_en, mem_response_en, master_en, parity_action_en,
            fast_b2b_en}, 32'h0);
        // A write while the clock enable is low must not land
        clk_en <= 1'b0;
        wr(8'h04, 32'h0000_0041, 5'h00);
        clk_en <= 1'b1;
        pm.drive_perr(2);
        repeat (3) @(posedge core_clk);
        rd(8'h04, 32'h82B0_0000);
        close_out;
    end
endmodule // bridge_primary_cmd_status_regs_test
